// File: ddccfg_defs.svh
// Register offsets, field positions, reset values and serial frame lengths
`ifndef DDCCFG_DEFS_SVH
`define DDCCFG_DEFS_SVH
`define DDCCFG_ADDR_W 15
`define DDCCFG_ADDR_PHOFF_TOP 15'h0362
`define DDCCFG_ADDR_TEST_EN 15'h0367
`define DDCCFG_ADDR_CTRL3 15'h0370
`define DDCCFG_ADDR_EXTDEC3 15'h0371
`define DDCCFG_RST_PHOFF_TOP 8'h00
`define DDCCFG_RST_TEST_EN 8'h00
`define DDCCFG_RST_CTRL3 8'h00
`define DDCCFG_RST_EXTDEC3 4'h0
`define DDCCFG_TEST_Q_BIT 2
`define DDCCFG_TEST_I_BIT 0
`define DDCCFG_MIX_BIT 7
`define DDCCFG_GAIN_BIT 6
`define DDCCFG_IF_MSB 5
`define DDCCFG_IF_LSB 4
`define DDCCFG_C2R_BIT 3
`define DDCCFG_DEC_MSB 2
`define DDCCFG_EXT_MSB 7
`define DDCCFG_EXT_LSB 4
`define DDCCFG_DEC_USE_EXT 3'h7
`define DDCCFG_PHASE_W 48
`define DDCCFG_SPI_INSTR_LAST 5'h0F
`define DDCCFG_SPI_DATA_LAST 5'h07
`define DDCCFG_SPI_READ_END 5'h08
`define DDCCFG_FIFO_DEPTH 32
`endif

// File: ddccfg_fifo.sv
// Sample FIFO with registered output and early-deasserting ready
`timescale 1ns/1ps
module ddccfg_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 32
) (
	input wire logic clock, // Sample clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic ce, // Clock enable
	input wire logic pushValid, // Write request
	output logic pushReady, // Room for two more words
	input wire logic [W-1:0] pushData, // Write data
	output logic popValid, // Output word valid
	input wire logic popReady, // Consumer takes word
	output logic [W-1:0] popData // Output word
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ready;
		logic oValid;
		logic [W-1:0] oData;
	} ddccfg_fifo_st_t;
	ddccfg_fifo_st_t st_r, st_nxt;
	logic [W-1:0] mem [DEPTH];
	logic push;
	logic load;

	always_comb begin
		st_nxt = st_r;
		// The word staged before ready fell still lands in the spare slot
		push = pushValid && (st_r.cnt != (AW+1)'(DEPTH));
		load = (!st_r.oValid || popReady) && (st_r.cnt != '0);
		if (popReady && st_r.oValid)
			st_nxt.oValid = 1'b0;
		if (load) begin
			st_nxt.oValid = 1'b1;
			st_nxt.oData = mem[st_r.rp];
			st_nxt.rp = st_r.rp + 1'b1;
		end
		if (push)
			st_nxt.wp = st_r.wp + 1'b1;
		st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
		// One slot kept spare for the word already in the stage register
		st_nxt.ready = st_nxt.cnt <= (AW+1)'(DEPTH - 2);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= '{wp: '0, rp: '0, cnt: '0, ready: 1'b1, oValid: 1'b0, oData: '0};
		end else if (ce) begin
			st_r <= st_nxt;
			if (push)
				mem[st_r.wp] <= pushData;
		end
	end

	assign pushReady = st_r.ready;
	assign popValid = st_r.oValid;
	assign popData = st_r.oData;
endmodule : ddccfg_fifo

// File: ddccfg_host.sv
// Host model of the serial control port
`timescale 1ns/1ps
module ddccfg_host (
	input wire logic clock, // Sample clock
	output logic spiClk, // Serial clock
	output logic spiCs_n, // Select
	output logic sdioIn, // Data to device
	input wire logic sdioOut, // Data from device
	input wire logic sdioOe_n // Device drives
);
	initial begin
		spiClk = 1'b0;
		spiCs_n = 1'b1;
		sdioIn = 1'b0;
	end
	// Each serial clock level lasts four sample clocks; clock rests low between frames
	task automatic half(input logic lvl);
		spiClk = lvl;
		repeat (4) @(negedge clock);
	endtask : half
	task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [23:0] w;
		w = {rd, a, wd};
		@(negedge clock);
		spiCs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			// Released line shows the inverse of its last level
			sdioIn = (rd && i < 8) ? ~sdioIn : w[i];
			half(1'b0);
			q[i % 8] = sdioOe_n ? 1'bx : sdioOut;
			half(1'b1);
		end
		half(1'b0);
		spiCs_n = 1'b1;
		repeat (2) @(negedge clock);
	endtask : xfer
endmodule : ddccfg_host

// File: ddccfg_mix.sv
// Combinational mixer: source routing, quadrant rotation and gain
`timescale 1ns/1ps
module ddccfg_mix #(
	parameter int W = 16
) (
	input wire logic [W-1:0] inI, // In-phase input sample
	input wire logic [W-1:0] inQ, // Quadrature input sample
	input wire logic complexMix, // 1 complex mixer, 0 real mixer
	input wire logic gain6dB, // Double the result
	input wire ddccfg_pkg::ddccfg_if_t ifMode, // Mixing mode
	input wire logic [1:0] quad, // Oscillator phase quadrant
	output logic [W-1:0] outI, // Mixed in-phase
	output logic [W-1:0] outQ // Mixed quadrature
);
	logic [W-1:0] srcQ;
	logic [W-1:0] rotI;
	logic [W-1:0] rotQ;

	always_comb begin
		// Real mixer takes both paths from the same real channel
		srcQ = complexMix ? inQ : inI;
		rotI = inI;
		rotQ = srcQ;
		unique case (ifMode)
			ddccfg_pkg::IF_ZERO: begin
				rotI = inI;
				rotQ = srcQ;
			end
			ddccfg_pkg::IF_TEST: begin
				rotI = {1'b0, {(W-1){1'b1}}};
				rotQ = '0;
			end
			ddccfg_pkg::IF_VARIABLE, ddccfg_pkg::IF_SAMPLE_RATE: begin
				unique case (quad)
					2'h0: begin
						rotI = inI;
						rotQ = srcQ;
					end
					2'h1: begin
						rotI = -srcQ;
						rotQ = inI;
					end
					2'h2: begin
						rotI = -inI;
						rotQ = -srcQ;
					end
					2'h3: begin
						rotI = srcQ;
						rotQ = -inI;
					end
				endcase
			end
		endcase
		outI = gain6dB ? {rotI[W-2:0], 1'b0} : rotI;
		outQ = gain6dB ? {rotQ[W-2:0], 1'b0} : rotQ;
	end
endmodule : ddccfg_mix

// File: ddccfg_pkg.sv
// Types shared by the downconverter configuration block
package ddccfg_pkg;
	typedef enum logic [1:0] {IF_VARIABLE, IF_ZERO, IF_SAMPLE_RATE, IF_TEST} ddccfg_if_t;
	typedef enum logic [2:0] {SP_IDLE, SP_INSTR, SP_WDATA, SP_RDATA, SP_DONE} ddccfg_spi_t;

	// Complex-output decimation factor of the selected filter cascade
	function automatic logic [5:0] decimFactor(logic [2:0] code, logic [3:0] ext);
		logic [5:0] f;
		f = 6'h04;
		unique case (code)
			3'h0: f = 6'h04;
			3'h1: f = 6'h08;
			3'h2: f = 6'h10;
			3'h3: f = 6'h02;
			3'h4: f = 6'h06;
			3'h5: f = 6'h0C;
			3'h6: f = 6'h18;
			3'h7: begin
				unique case (ext)
					4'h2: f = 6'h0A;
					4'h3: f = 6'h14;
					4'h4: f = 6'h28;
					default: f = 6'h30;
				endcase
			end
		endcase
		return f;
	endfunction : decimFactor
endpackage : ddccfg_pkg

// File: ddccfg_top.sv
// Downconverter channel configuration registers, serial port and sample datapath
`timescale 1ns/1ps
`include "ddccfg_defs.svh"
module ddccfg_top #(
	parameter int W = 16,
	parameter int FIFO_DEPTH = `DDCCFG_FIFO_DEPTH
) (
	input wire logic clock, // Sample clock, 200 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic spiClk, // Serial port clock, sampled
	input wire logic spiCs_n, // Serial port select, active low
	input wire logic sdioIn, // Serial data pin, input side
	output logic sdioOut, // Serial data pin, output side
	output logic sdioOe_n, // Serial data pin drive enable, active low
	input wire logic [`DDCCFG_PHASE_W-1:0] phaseInc, // Oscillator phase increment
	input wire logic inValid, // Input sample valid
	output logic inReady, // Input sample accepted
	input wire logic [W-1:0] inI, // Input in-phase sample
	input wire logic [W-1:0] inQ, // Input quadrature sample
	input wire logic [W-1:0] patA, // Test pattern generator A
	input wire logic [W-1:0] patB, // Test pattern generator B
	output logic outValid, // Output sample valid
	input wire logic outReady, // Consumer takes output sample
	output logic [W-1:0] outI, // Output in-phase sample
	output logic [W-1:0] outQ // Output quadrature sample
);
	typedef struct packed {
		logic [7:0] phOffTop;
		logic qTestEn;
		logic iTestEn;
		logic [7:0] ctrl;
		logic [3:0] extDec;
		logic sclkPrev;
		ddccfg_pkg::ddccfg_spi_t spi;
		logic [4:0] bitCnt;
		logic [15:0] instr;
		logic [7:0] shift;
		logic sdo;
		logic sdoOe_n;
		logic [`DDCCFG_PHASE_W-1:0] acc;
		logic [5:0] decCnt;
		logic [1:0] c2rPh;
		logic stgValid;
		logic [W-1:0] stgI;
		logic [W-1:0] stgQ;
	} ddccfg_st_t;

	ddccfg_st_t st_r, st_nxt;
	logic fifoReady;
	logic accept;
	logic sclkRise;
	logic sclkFall;
	logic [15:0] instrNew;
	logic [7:0] shiftNew;
	logic [`DDCCFG_ADDR_W-1:0] addr;
	logic [`DDCCFG_PHASE_W-1:0] phase;
	logic [1:0] quad;
	logic [5:0] factor;
	logic complexMix;
	logic gain6dB;
	logic c2r;
	ddccfg_pkg::ddccfg_if_t ifMode;
	logic [W-1:0] mixI;
	logic [W-1:0] mixQ;
	logic [W-1:0] realI;

	// Register readback, reserved bits read as zero
	function automatic logic [7:0] readReg(ddccfg_st_t s, logic [`DDCCFG_ADDR_W-1:0] a);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			`DDCCFG_ADDR_PHOFF_TOP: d = s.phOffTop;
			`DDCCFG_ADDR_TEST_EN: begin
				d[`DDCCFG_TEST_Q_BIT] = s.qTestEn;
				d[`DDCCFG_TEST_I_BIT] = s.iTestEn;
			end
			`DDCCFG_ADDR_CTRL3: d = s.ctrl;
			`DDCCFG_ADDR_EXTDEC3: d[`DDCCFG_EXT_MSB:`DDCCFG_EXT_LSB] = s.extDec;
			default: d = 8'h00;
		endcase
		return d;
	endfunction : readReg

	// Decoded control fields
	always_comb begin
		complexMix = st_r.ctrl[`DDCCFG_MIX_BIT];
		gain6dB = st_r.ctrl[`DDCCFG_GAIN_BIT];
		ifMode = ddccfg_pkg::ddccfg_if_t'(st_r.ctrl[`DDCCFG_IF_MSB:`DDCCFG_IF_LSB]);
		c2r = st_r.ctrl[`DDCCFG_C2R_BIT];
		factor = ddccfg_pkg::decimFactor(st_r.ctrl[`DDCCFG_DEC_MSB:0], st_r.extDec);
		// Real output halves the ratio
		if (c2r)
			factor = {1'b0, factor[5:1]};
		// Oscillator phase with the offset added in its top byte
		phase = st_r.acc + {st_r.phOffTop, 40'h00_0000_0000};
		if (ifMode == ddccfg_pkg::IF_SAMPLE_RATE)
			quad = st_r.phOffTop[7:6];
		else
			quad = phase[`DDCCFG_PHASE_W-1:`DDCCFG_PHASE_W-2];
	end

	ddccfg_mix #(
		.W(W)
	) u_mix (
		.inI(inI),
		.inQ(inQ),
		.complexMix(complexMix),
		.gain6dB(gain6dB),
		.ifMode(ifMode),
		.quad(quad),
		.outI(mixI),
		.outQ(mixQ)
	);

	// Quarter-rate mixing sequence turns the complex pair into one real stream
	always_comb begin
		unique case (st_r.c2rPh)
			2'h0: realI = mixI;
			2'h1: realI = -mixQ;
			2'h2: realI = -mixI;
			2'h3: realI = mixQ;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		accept = inValid && fifoReady;
		sclkRise = spiClk && !st_r.sclkPrev;
		sclkFall = !spiClk && st_r.sclkPrev;
		instrNew = {st_r.instr[14:0], sdioIn};
		shiftNew = {st_r.shift[6:0], sdioIn};
		addr = st_r.instr[`DDCCFG_ADDR_W-1:0];
		st_nxt.sclkPrev = spiClk;

		// Serial port: 16-bit instruction (read flag, address), then 8 data bits
		if (spiCs_n) begin
			st_nxt.spi = ddccfg_pkg::SP_IDLE;
			st_nxt.bitCnt = 5'h00;
			st_nxt.sdoOe_n = 1'b1;
		end else begin
			unique case (st_r.spi)
				ddccfg_pkg::SP_IDLE, ddccfg_pkg::SP_INSTR: begin
					if (sclkRise) begin
						st_nxt.instr = instrNew;
						st_nxt.bitCnt = st_r.bitCnt + 5'h01;
						st_nxt.spi = ddccfg_pkg::SP_INSTR;
						if (st_r.bitCnt == `DDCCFG_SPI_INSTR_LAST) begin
							st_nxt.bitCnt = 5'h00;
							if (instrNew[15]) begin
								st_nxt.spi = ddccfg_pkg::SP_RDATA;
								st_nxt.shift = readReg(st_r, instrNew[`DDCCFG_ADDR_W-1:0]);
							end else begin
								st_nxt.spi = ddccfg_pkg::SP_WDATA;
							end
						end
					end
				end
				ddccfg_pkg::SP_WDATA: begin
					if (sclkRise) begin
						st_nxt.shift = shiftNew;
						st_nxt.bitCnt = st_r.bitCnt + 5'h01;
						if (st_r.bitCnt == `DDCCFG_SPI_DATA_LAST) begin
							st_nxt.spi = ddccfg_pkg::SP_DONE;
							unique case (addr)
								`DDCCFG_ADDR_PHOFF_TOP: st_nxt.phOffTop = shiftNew;
								`DDCCFG_ADDR_TEST_EN: begin
									st_nxt.qTestEn = shiftNew[`DDCCFG_TEST_Q_BIT];
									st_nxt.iTestEn = shiftNew[`DDCCFG_TEST_I_BIT];
								end
								`DDCCFG_ADDR_CTRL3: st_nxt.ctrl = shiftNew;
								`DDCCFG_ADDR_EXTDEC3: begin
									st_nxt.extDec = shiftNew[`DDCCFG_EXT_MSB:`DDCCFG_EXT_LSB];
								end
								default: st_nxt.ctrl = st_r.ctrl;
							endcase
						end
					end
				end
				ddccfg_pkg::SP_RDATA: begin
					// Read data leaves MSB first, changing on falling edges
					if (sclkFall) begin
						if (st_r.bitCnt == `DDCCFG_SPI_READ_END) begin
							st_nxt.spi = ddccfg_pkg::SP_DONE;
							st_nxt.sdoOe_n = 1'b1;
						end else begin
							st_nxt.sdo = st_r.shift[7];
							st_nxt.shift = {st_r.shift[6:0], 1'b0};
							st_nxt.sdoOe_n = 1'b0;
							st_nxt.bitCnt = st_r.bitCnt + 5'h01;
						end
					end
				end
				ddccfg_pkg::SP_DONE: st_nxt.sdoOe_n = 1'b1;
				default: st_nxt.spi = ddccfg_pkg::SP_IDLE;
			endcase
		end

		// Datapath: oscillator, decimation keep/drop, test substitution
		st_nxt.stgValid = 1'b0;
		if (accept) begin
			st_nxt.acc = st_r.acc + phaseInc;
			if (st_r.decCnt == 6'h00) begin
				st_nxt.decCnt = factor - 6'h01;
				st_nxt.stgValid = 1'b1;
				st_nxt.c2rPh = st_r.c2rPh + 2'h1;
				st_nxt.stgI = c2r ? realI : mixI;
				st_nxt.stgQ = c2r ? '0 : mixQ;
				if (st_r.iTestEn)
					st_nxt.stgI = patA;
				if (st_r.qTestEn)
					st_nxt.stgQ = patB;
			end else begin
				st_nxt.decCnt = st_r.decCnt - 6'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= '{
				phOffTop: `DDCCFG_RST_PHOFF_TOP,
				qTestEn: 1'b0,
				iTestEn: 1'b0,
				ctrl: `DDCCFG_RST_CTRL3,
				extDec: `DDCCFG_RST_EXTDEC3,
				sclkPrev: 1'b0,
				spi: ddccfg_pkg::SP_IDLE,
				bitCnt: 5'h00,
				instr: 16'h0000,
				shift: 8'h00,
				sdo: 1'b0,
				sdoOe_n: 1'b1,
				acc: '0,
				decCnt: 6'h00,
				c2rPh: 2'h0,
				stgValid: 1'b0,
				stgI: '0,
				stgQ: '0
			};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	ddccfg_fifo #(
		.W(2*W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.pushValid(st_r.stgValid),
		.pushReady(fifoReady),
		.pushData({st_r.stgI, st_r.stgQ}),
		.popValid(outValid),
		.popReady(outReady),
		.popData({outI, outQ})
	);

	assign inReady = fifoReady;
	assign sdioOut = st_r.sdo;
	assign sdioOe_n = st_r.sdoOe_n;
endmodule : ddccfg_top

// File: ddccfg_top_properties.sv
// Port assertions for the configuration block
`timescale 1ns/1ps
module ddccfg_props #(
	parameter int W = 16
) (
	input wire logic clock, // Clock
	input wire logic rst, // Reset
	input wire logic ce, // Enable
	input wire logic spiClk, // Serial clock
	input wire logic spiCs_n, // Select
	input wire logic sdioIn, // Serial in
	input wire logic sdioOut, // Serial out
	input wire logic sdioOe_n, // Drive
	input wire logic [47:0] phaseInc, // Increment
	input wire logic inValid, // In valid
	input wire logic inReady, // In ready
	input wire logic [W-1:0] inI, // In I
	input wire logic [W-1:0] inQ, // In Q
	input wire logic [W-1:0] patA, // Pattern A
	input wire logic [W-1:0] patB, // Pattern B
	input wire logic outValid, // Out valid
	input wire logic outReady, // Out ready
	input wire logic [W-1:0] outI, // Out I
	input wire logic [W-1:0] outQ // Out Q
);
	logic clkD_r;
	logic isRead_r;
	logic [4:0] rises_r;
	logic [3:0] falls_r;
	wire rise = spiClk && !clkD_r;
	wire fall = !spiClk && clkD_r;
	// Frame position as seen on the pins
	always_ff @(posedge clock) begin
		clkD_r <= spiClk;
		if (rst || spiCs_n) begin
			rises_r <= 5'h00;
			falls_r <= 4'h0;
			isRead_r <= 1'b0;
		end else begin
			if (rise && rises_r != 5'h1F) rises_r <= rises_r + 5'h01;
			if (rise && rises_r == 5'h00) isRead_r <= sdioIn;
			if (fall && rises_r >= 5'h10 && falls_r != 4'hF) falls_r <= falls_r + 4'h1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_reset_outputs: assert property ($fell(rst) |-> !outValid && sdioOe_n && inReady
		&& outI == '0 && outQ == '0) else $error("outputs not cleared");
	chk_quiet_start: assert property ($fell(spiCs_n) |=> sdioOe_n [*8])
		else $error("pin driven early");
	chk_read_drive: assert property (isRead_r && fall && rises_r == 5'h10 && falls_r == 4'h0
		|-> ##[1:3] !sdioOe_n) else $error("read not driven");
	chk_read_release: assert property (fall && falls_r == 4'h8 |-> ##[1:3] sdioOe_n)
		else $error("pin held after byte");
	chk_write_quiet: assert property (!isRead_r && rises_r != 5'h00 |-> sdioOe_n)
		else $error("pin driven in write");
	chk_cs_release: assert property (spiCs_n |=> sdioOe_n)
		else $error("pin held deselected");
	chk_out_hold: assert property (outValid && !outReady && ce |=> outValid
		&& $stable(outI) && $stable(outQ)) else $error("output moved while stalled");
	chk_out_latency: assert property ($fell(rst) |-> !outValid [*3])
		else $error("output too early");
endmodule : ddccfg_props

// File: testbench.sv
// Self-checking bench for the configuration block
`timescale 1ns/1ps
`include "ddccfg_defs.svh"
module testbench;
	logic clock, spiClk, spiCs_n, sdioIn, sdioOut, sdioOe_n, inReady, outValid;
	logic rst = 1'b1, ce = 1'b1, inValid = 1'b0, outReady = 1'b1;
	logic [47:0] phaseInc = 48'h0;
	logic [15:0] inI = 16'h0000, inQ = 16'h0000, patA = 16'hA5A5, patB = 16'h5A5A, outI, outQ;
	logic [7:0] offTop = 8'h00, rd;
	logic [31:0] got[$];
	int errors = 0, cmp_count = 0, cycles = 0;
	ddccfg_top u_ddccfg_top (.clock, .rst, .ce, .spiClk, .spiCs_n, .sdioIn, .sdioOut, .sdioOe_n,
		.phaseInc, .inValid, .inReady, .inI, .inQ, .patA, .patB, .outValid, .outReady, .outI, .outQ);
	ddccfg_host host (.clock, .spiClk, .spiCs_n, .sdioIn, .sdioOut, .sdioOe_n);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic finish_test();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	always @(posedge clock) begin
		cycles++;
		if (!rst && outValid && outReady) got.push_back({outI, outQ});
		if (cycles == 80000) begin
			errors++;
			finish_test();
		end
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(logic [14:0] a, logic [7:0] d);
		host.xfer(1'b0, a, d, rd);
	endtask : wr
	task automatic restart();
		@(negedge clock);
		rst = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
	endtask : restart
	// Sample value is a fixed base (I 0x0100, Q 0x2000) plus its acceptance index
	task automatic feed(int n, int tries, output int took);
		logic r;
		r = 1'b0;
		took = 0;
		while (took < n && tries > 0) begin
			@(negedge clock);
			if (r) took++;
			tries--;
			inValid = took < n && tries > 0;
			inI = 16'h0100 + took[15:0];
			inQ = 16'h2000 + took[15:0];
			r = inValid && inReady;
		end
	endtask : feed
	task automatic drain(logic stall);
		int quiet;
		quiet = 0;
		while (quiet < 8) begin
			@(negedge clock);
			outReady = stall ? ~outReady : 1'b1;
			quiet = outValid ? 0 : quiet + 1;
		end
		outReady = 1'b1;
	endtask : drain
	function automatic logic [31:0] predict(logic [7:0] c, logic [7:0] t, int j, int idx);
		logic [15:0] i;
		logic [15:0] q;
		i = c[5:4] == 2'h3 ? 16'h7FFF : 16'h0100 + idx[15:0];
		q = c[5:4] == 2'h3 ? 16'h0000 : c[7] ? 16'h2000 + idx[15:0] : i;
		if (!c[4] && offTop[7]) {i, q} = {-i, -q};
		if (c[6]) {i, q} = {i << 1, q << 1};
		if (c[3]) {i, q} = {j % 4 == 0 ? i : j % 4 == 1 ? -q : j % 4 == 2 ? -i : q, 16'h0000};
		if (t[0]) i = patA;
		if (t[2]) q = patB;
		return {i, q};
	endfunction : predict
	task automatic run(logic [7:0] c, logic [7:0] x, logic [7:0] t, logic [7:0] o, int f);
		int took;
		restart();
		offTop = o;
		wr(`DDCCFG_ADDR_CTRL3, c);
		wr(`DDCCFG_ADDR_EXTDEC3, x);
		wr(`DDCCFG_ADDR_TEST_EN, t);
		wr(`DDCCFG_ADDR_PHOFF_TOP, o);
		got.delete();
		feed(3 * f, 100000, took);
		drain(1'b0);
		check("word count", got.size(), 3);
		for (int k = 0; k < 3; k++) check("sample", got[k], predict(c, t, k, k * f));
	endtask : run
	task automatic t_regs();
		logic [14:0] ad[5] = '{15'h0362, 15'h0367, 15'h0370, 15'h0371, 15'h0363};
		logic [7:0] rb[5] = '{8'hA5, 8'h05, 8'hA5, 8'hA0, 8'h00};
		restart();
		ce = 1'b0;
		wr(`DDCCFG_ADDR_PHOFF_TOP, 8'h3C);
		ce = 1'b1;
		host.xfer(1'b1, `DDCCFG_ADDR_PHOFF_TOP, 8'h00, rd);
		check("frozen write", rd, 8'h00);
		for (int e = 0; e < 5; e++) begin
			host.xfer(1'b1, ad[e], 8'h00, rd);
			check("reset value", rd, 8'h00);
			wr(ad[e], 8'hA5);
			host.xfer(1'b1, ad[e], 8'h00, rd);
			check("readback", rd, rb[e]);
		end
	endtask : t_regs
	// Code, extended code and complex factor; unlisted extended code acts as full cascade
	task automatic t_decim();
		logic [15:0] tab[13] = '{16'h0004, 16'h1008, 16'h2010, 16'h3002, 16'h4006, 16'h500C,
			16'h6018, 16'h7030, 16'h720A, 16'h7314, 16'h7428, 16'h3402, 16'h7130};
		for (int e = 0; e < 13; e++) begin
			for (int r = 0; r < 2; r++) begin
				run({4'h9, r[0], tab[e][14:12]}, {tab[e][11:8], 4'h0}, 8'h00, 8'h00,
					tab[e][7:0] >> r);
			end
		end
	endtask : t_decim
	task automatic t_mix();
		run(8'h13, 8'h00, 8'h00, 8'h00, 2);
		run(8'hD3, 8'h00, 8'h00, 8'h00, 2);
		run(8'hB3, 8'h00, 8'h00, 8'h00, 2);
		run(8'h83, 8'h00, 8'h00, 8'h80, 2);
		run(8'hA3, 8'h00, 8'h00, 8'h80, 2);
		run(8'h93, 8'h00, 8'h01, 8'h00, 2);
		run(8'h93, 8'h00, 8'h04, 8'h00, 2);
		run(8'h93, 8'h00, 8'h05, 8'h00, 2);
	endtask : t_mix
	task automatic t_fifo();
		int took;
		restart();
		offTop = 8'h00;
		wr(`DDCCFG_ADDR_CTRL3, 8'h93);
		outReady = 1'b0;
		got.delete();
		feed(200, 150, took);
		check("refused when full", {inReady, took >= 58 && took <= 66}, 2'b01);
		drain(1'b1);
		check("drained count", got.size(), (took + 1) / 2);
		for (int k = 0; k < got.size(); k++)
			check("drained", got[k], predict(8'h93, 8'h00, k, 2 * k));
	endtask : t_fifo
	initial begin
		repeat (16) @(negedge clock);
		rst = 1'b0;
		t_regs();
		t_decim();
		t_mix();
		t_fifo();
		finish_test();
	end
endmodule : testbench
bind ddccfg_top ddccfg_props #(.W(W)) u_props (.clock, .rst, .ce, .spiClk, .spiCs_n, .sdioIn,
	.sdioOut, .sdioOe_n, .phaseInc, .inValid, .inReady, .inI, .inQ, .patA, .patB, .outValid,
	.outReady, .outI, .outQ);
